//--- include/bsp_pkg.sv
// package for the buck pair set-point register block
// Contract
// - Bit 6 of the normal set point is read-only, set only by default or fuse configuration.
// - With range bit 0 the six low bits select 0.40 V to 1.975 V in 25 mV steps.
// - With range bit 1 the six low bits select 0.800 V to 3.300 V in 50 mV steps.
// - Normal, standby and sleep have separate 6-bit codes and the current mode's is applied.
// - The initial normal range bit is copied into the standby and sleep range bits.
// - Code 1000000 is 0.8000 V, each high code adds 50 mV, each low code 25 mV above 0.4000 V.
// - Registers 0x3C, 0x3D, 0x3E: bits 5:0 read/write, bit 6 read-only, bit 7 unused, reset 0.
package bsp_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] ADDR_NORMAL = 8'h3C;
    localparam logic [7:0] ADDR_STANDBY = 8'h3D;
    localparam logic [7:0] ADDR_SLEEP = 8'h3E;
    localparam int CODE_LSB = 0;
    localparam int CODE_MSB = 5;
    localparam int RANGE_BIT = 6;
    localparam logic [5:0] CODE_RESET = 6'h00;
    localparam logic RANGE_RESET = 1'b0;
    // ****************************************
    // voltage decode, millivolts
    // ****************************************
    localparam logic [11:0] LOW_BASE_MV = 12'h190;   // 400
    localparam logic [11:0] LOW_STEP_MV = 12'h019;   // 25
    localparam logic [11:0] HIGH_BASE_MV = 12'h320;  // 800
    localparam logic [11:0] HIGH_STEP_MV = 12'h032;  // 50
    localparam logic [11:0] MAX_MV = 12'hCE4;        // 3300
    // ****************************************
    // types
    // ****************************************
    typedef enum logic [2:0] {
        BSP_NORMAL = 3'b001,
        BSP_STANDBY = 3'b010,
        BSP_SLEEP = 3'b100
    } bsp_mode_e;
    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } bsp_req_s;
endpackage

//--- tb/bsp_setpoint_properties.sv
// checker for the buck pair set-point register block
`timescale 1ns/10ps
module bsp_setpoint_props (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic cfg_load,
    input wire logic cfg_range,
    input wire bsp_pkg::bsp_req_s req,
    input wire bsp_pkg::bsp_mode_e mode,
    input wire logic [7:0] rdata,
    input wire logic [6:0] active_code,
    input wire logic [11:0] active_mv,
    input wire logic active_reserved
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    sequence wr_normal_s;
        req.wr && req.addr == bsp_pkg::ADDR_NORMAL && mode == bsp_pkg::BSP_NORMAL;
    endsequence
    sequence wr_sleep_s;
        req.wr && req.addr == bsp_pkg::ADDR_SLEEP;
    endsequence
    sequence normal_then_idle_s;
        wr_normal_s ##1 (mode == bsp_pkg::BSP_NORMAL && !req.wr);
    endsequence
    sequence sleep_then_read_s;
        wr_sleep_s ##1 (req.addr == bsp_pkg::ADDR_SLEEP && !req.wr);
    endsequence
    unused_zero_a: assert property (rdata[7] == 1'b0) else $error("bit 7 set");
    low_decode_a: assert property (!active_code[6] |-> active_mv ==
        bsp_pkg::LOW_BASE_MV + bsp_pkg::LOW_STEP_MV * active_code[5:0]) else $error("low mv");
    high_decode_a: assert property (active_code[6] |-> active_mv ==
        bsp_pkg::HIGH_BASE_MV + bsp_pkg::HIGH_STEP_MV * active_code[5:0]) else $error("high mv");
    reserved_flag_a: assert property (active_reserved == (active_code > 7'h72))
        else $error("reserved flag");
    range_hold_a: assert property (!cfg_load [*2] |=> $stable(active_code[6]))
        else $error("range moved");
    normal_apply_a: assert property (normal_then_idle_s |=>
        active_code[5:0] == $past(req.wdata[5:0], 2)) else $error("normal code");
    unmapped_read_a: assert property (req.addr == 8'h3F |=> rdata == 8'h00)
        else $error("unmapped read");
    sleep_readback_a: assert property (sleep_then_read_s |=>
        rdata[5:0] == $past(req.wdata[5:0], 2)) else $error("sleep readback");
endmodule // bsp_setpoint_props
bind bsp_setpoint_regs bsp_setpoint_props u_props (.clk_sys(clk_sys), .rstn(rstn),
    .cfg_load(cfg_load), .cfg_range(cfg_range), .req(req), .mode(mode), .rdata(rdata),
    .active_code(active_code), .active_mv(active_mv), .active_reserved(active_reserved));

//--- tb/tb_bsp_setpoint_regs.sv
// self-checking bench for the buck pair set-point register block
`timescale 1ns/10ps
module tb_bsp_setpoint_regs;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic cfg_load = 1'b0;
    logic cfg_range = 1'b0;
    bsp_pkg::bsp_req_s req = '0;
    bsp_pkg::bsp_mode_e mode = bsp_pkg::BSP_NORMAL;
    logic [7:0] rdata;
    logic [6:0] active_code;
    logic [11:0] active_mv;
    logic active_reserved;
    int err_count = 0;
    int samples_checked = 0;
    // first regulator only, the second would take mirrored writes
    bsp_setpoint_regs dut (.clk_sys(clk_sys), .rstn(rstn), .cfg_load(cfg_load),
        .cfg_range(cfg_range), .req(req), .mode(mode), .rdata(rdata),
        .active_code(active_code), .active_mv(active_mv), .active_reserved(active_reserved));
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic put(input logic wr, input logic [7:0] addr, input logic [7:0] wdata);
        @(posedge clk_sys);
        req <= '{wr, addr, wdata};
    endtask
    task automatic rd(input logic [7:0] addr);
        put(1'b0, addr, 8'h00);
        @(posedge clk_sys);
        #1;
    endtask
    task automatic settle(input bsp_pkg::bsp_mode_e m);
        @(posedge clk_sys);
        mode <= m;
        repeat (3) @(posedge clk_sys);
        #1;
    endtask
    task automatic load(input logic r);
        @(posedge clk_sys);
        cfg_range <= r;
        cfg_load <= 1'b1;
        @(posedge clk_sys);
        cfg_load <= 1'b0;
    endtask
    task automatic t_reset();
        for (int a = 8'h3C; a <= 8'h3F; a++) begin
            rd(8'(a));
            chk(12'(rdata), 12'h000);
        end
        chk(active_mv, 12'h190);
        $display("test reset done");
    endtask
    task automatic t_high();
        load(1'b1);
        put(1'b1, bsp_pkg::ADDR_NORMAL, 8'h9E);
        put(1'b1, bsp_pkg::ADDR_STANDBY, 8'h18);
        put(1'b1, bsp_pkg::ADDR_SLEEP, 8'h32);
        rd(bsp_pkg::ADDR_SLEEP);
        chk(12'(rdata), 12'h072);
        rd(bsp_pkg::ADDR_NORMAL);
        chk(12'(rdata), 12'h05E);
        settle(bsp_pkg::BSP_NORMAL);
        chk({11'h000, active_reserved}, 12'h000);
        chk(active_mv, 12'h8FC);
        chk(12'(active_code), 12'h05E);
        settle(bsp_pkg::BSP_STANDBY);
        chk(active_mv, 12'h7D0);
        settle(bsp_pkg::BSP_SLEEP);
        chk(active_mv, 12'hCE4);
        chk({11'h000, active_reserved}, 12'h000);
        $display("test high range done");
    endtask
    task automatic t_low();
        load(1'b0);
        settle(bsp_pkg::BSP_NORMAL);
        put(1'b1, bsp_pkg::ADDR_NORMAL, 8'h3F);
        rd(bsp_pkg::ADDR_STANDBY);
        chk(12'(rdata), 12'h018);
        chk(active_mv, 12'h7B7);
        $display("test low range done");
    endtask
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        #20000;
        err_count++;
        tally_and_finish();
    end
    initial begin
        repeat (12) @(posedge clk_sys);
        rstn <= 1'b1;
        t_reset();
        t_high();
        t_low();
        tally_and_finish();
    end
endmodule // tb_bsp_setpoint_regs

//--- verilog/bsp_decode.sv
// decoder from 7-bit set-point code to millivolts
`timescale 1ns/10ps
module bsp_decode (
    input wire logic [6:0] code,
    output logic [11:0] mv,
    output logic reserved
);
    always_comb begin
        if (code[bsp_pkg::RANGE_BIT]) begin
            mv = bsp_pkg::HIGH_BASE_MV + 12'(code[5:0]) * bsp_pkg::HIGH_STEP_MV;
        end else begin
            mv = bsp_pkg::LOW_BASE_MV + 12'(code[5:0]) * bsp_pkg::LOW_STEP_MV;
        end
        reserved = (mv > bsp_pkg::MAX_MV);
    end
endmodule // bsp_decode

//--- verilog/bsp_setpoint_regs.sv
// set-point registers for the first regulator of the buck pair
`timescale 1ns/10ps
module bsp_setpoint_regs (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic cfg_load,
    input wire logic cfg_range,
    input wire bsp_pkg::bsp_req_s req,
    input wire bsp_pkg::bsp_mode_e mode,
    output logic [7:0] rdata,
    output logic [6:0] active_code,
    output logic [11:0] active_mv,
    output logic active_reserved
);
    logic [5:0] normal_setpoint;
    logic [5:0] standby_setpoint;
    logic [5:0] sleep_setpoint;
    logic normal_range;
    logic standby_range;
    logic sleep_range;
    logic [6:0] next_active_code;
    logic [11:0] dec_mv;
    logic dec_reserved;

    // ****************************************
    // helpers
    // ****************************************
    // code bits of a write, range and bit 7 dropped
    function automatic logic [5:0] code_field(input logic [7:0] data);
        return data[bsp_pkg::CODE_MSB:bsp_pkg::CODE_LSB];
    endfunction

    // ****************************************
    // range bits, loaded from configuration only
    // ****************************************
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            normal_range <= bsp_pkg::RANGE_RESET;
            standby_range <= bsp_pkg::RANGE_RESET;
            sleep_range <= bsp_pkg::RANGE_RESET;
        end else if (cfg_load) begin
            normal_range <= cfg_range;
            standby_range <= cfg_range;
            sleep_range <= cfg_range;
        end
    end

    // ****************************************
    // writable code fields
    // ****************************************
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            normal_setpoint <= bsp_pkg::CODE_RESET;
            standby_setpoint <= bsp_pkg::CODE_RESET;
            sleep_setpoint <= bsp_pkg::CODE_RESET;
        end else if (req.wr) begin
            // bit 6 and bit 7 of write data dropped
            unique case (req.addr)
                bsp_pkg::ADDR_NORMAL: begin
                    normal_setpoint <= code_field(req.wdata);
                end
                bsp_pkg::ADDR_STANDBY: begin
                    standby_setpoint <= code_field(req.wdata);
                end
                bsp_pkg::ADDR_SLEEP: begin
                    sleep_setpoint <= code_field(req.wdata);
                end
                default: begin
                end
            endcase
        end
    end

    // ****************************************
    // readback, registered
    // ****************************************
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rdata <= 8'h00;
        end else begin
            unique case (req.addr)
                bsp_pkg::ADDR_NORMAL: rdata <= {1'b0, normal_range, normal_setpoint};
                bsp_pkg::ADDR_STANDBY: rdata <= {1'b0, standby_range, standby_setpoint};
                bsp_pkg::ADDR_SLEEP: rdata <= {1'b0, sleep_range, sleep_setpoint};
                default: rdata <= 8'h00;
            endcase
        end
    end

    // ****************************************
    // mode selection and decode
    // ****************************************
    always_comb begin
        unique case (mode)
            bsp_pkg::BSP_NORMAL: next_active_code = {normal_range, normal_setpoint};
            bsp_pkg::BSP_STANDBY: next_active_code = {standby_range, standby_setpoint};
            bsp_pkg::BSP_SLEEP: next_active_code = {sleep_range, sleep_setpoint};
            default: next_active_code = {normal_range, normal_setpoint};
        endcase
    end

    bsp_decode u_decode (
        .code(next_active_code),
        .mv(dec_mv),
        .reserved(dec_reserved)
    );

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            active_code <= 7'h00;
            active_mv <= bsp_pkg::LOW_BASE_MV;
            active_reserved <= 1'b0;
        end else begin
            active_code <= next_active_code;
            active_mv <= dec_mv;
            active_reserved <= dec_reserved;
        end
    end
endmodule // bsp_setpoint_regs
